//--- shared/io_pin_reset_pkg.sv
`default_nettype none
package io_pin_reset_pkg;
   // line counts of the two ports
   localparam int NUM_A = 23;
   localparam int NUM_B = 13;
   localparam int DATA_W = 32;
   localparam int ADDR_W = 5;
   localparam int SYNC_STAGES = 2;

   // register byte addresses
   localparam logic [ADDR_W-1:0] OFS_PULL_A = 5'h00;
   localparam logic [ADDR_W-1:0] OFS_PULL_B = 5'h04;
   localparam logic [ADDR_W-1:0] OFS_GPIO_A = 5'h08;
   localparam logic [ADDR_W-1:0] OFS_GPIO_B = 5'h0C;
   localparam logic [ADDR_W-1:0] OFS_FUNC_RC = 5'h10;
   localparam logic [ADDR_W-1:0] OFS_PWR_CTRL = 5'h14;
   localparam logic [ADDR_W-1:0] OFS_STATUS = 5'h18;

   // line positions on port A, port B
   localparam int TCK_LINE = 0;
   localparam int TMS_LINE = 1;
   localparam int TDI_LINE = 2;
   localparam int TDO_LINE = 3;
   localparam int RC_LINE = 20;
   localparam int TWI_A0 = 5;
   localparam int TWI_A1 = 7;
   localparam int TWI_A2 = 17;
   localparam int TWI_A3 = 21;
   localparam int TWI_B0 = 4;
   localparam int TWI_B1 = 5;

   // peripheral function codes, A = 0 up to F
   localparam int FUNC_W = 3;
   localparam logic [FUNC_W-1:0] FUNC_F = 3'h5;

   // field positions
   localparam int KEEP_BIT = 0;
   localparam int STAT_JTAG = 0;
   localparam int STAT_RC = 1;

   // masks and reset values
   localparam logic [DATA_W-1:0] ONE = 32'h0000_0001;
   localparam logic [DATA_W-1:0] TCK_MASK = ONE << TCK_LINE;
   localparam logic [DATA_W-1:0] TDO_MASK = ONE << TDO_LINE;
   localparam logic [DATA_W-1:0] JTAG_PULL_MASK = TCK_MASK | (ONE << TMS_LINE) | (ONE << TDI_LINE);
   localparam logic [DATA_W-1:0] JTAG_MASK = JTAG_PULL_MASK | TDO_MASK;
   localparam logic [DATA_W-1:0] RC_MASK = ONE << RC_LINE;
   localparam logic [DATA_W-1:0] TWI_A_MASK =
      (ONE << TWI_A0) | (ONE << TWI_A1) | (ONE << TWI_A2) | (ONE << TWI_A3);
   localparam logic [DATA_W-1:0] TWI_B_MASK = (ONE << TWI_B0) | (ONE << TWI_B1);
   localparam logic [DATA_W-1:0] PULL_A_RST = TCK_MASK;
   localparam logic [DATA_W-1:0] PULL_B_RST = 32'h0000_0000;
   localparam logic [DATA_W-1:0] GPIO_A_RST = ~(TWI_A_MASK | RC_MASK);
   localparam logic [DATA_W-1:0] GPIO_B_RST = ~TWI_B_MASK;
endpackage
`default_nettype wire

//--- hw/io_pin_reset_defaults.sv
// The register addresses and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module io_pin_reset_defaults #(
   parameter int LINES_A = io_pin_reset_pkg::NUM_A,
   parameter int LINES_B = io_pin_reset_pkg::NUM_B
) (
   // clock and resets
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic powerUp_n,
   // register port
   input wire logic [io_pin_reset_pkg::ADDR_W-1:0] regAddr,
   input wire logic [io_pin_reset_pkg::DATA_W-1:0] regWrData,
   input wire logic regWrite,
   input wire logic regRead,
   output logic [io_pin_reset_pkg::DATA_W-1:0] regRdData,
   // pins sampled from outside
   input wire logic tckPin,
   input wire logic rcOscClk,
   // line control
   output logic [LINES_A-1:0] pullUpA,
   output logic [LINES_B-1:0] pullUpB,
   output logic [LINES_A-1:0] gpioOwnA,
   output logic [LINES_B-1:0] gpioOwnB,
   output logic [io_pin_reset_pkg::FUNC_W-1:0] rcLineFunc,
   // jtag port
   output logic jtagOwn,
   output logic tdoOutEnable,
   // rc clock on line twenty
   output logic rcClkOut,
   output logic rcClkOutEnable
);
   import io_pin_reset_pkg::*;

   // refused at elaboration: the register map holds at most one word per port
   if (LINES_A > DATA_W || LINES_B > DATA_W || LINES_A <= RC_LINE || LINES_B <= TWI_B1) begin
      $error("io_pin_reset_defaults: line counts out of range");
   end

   // software registers
   logic [LINES_A-1:0] pullA_r, pullA_nxt;
   logic [LINES_B-1:0] pullB_r, pullB_nxt;
   logic [LINES_A-1:0] gpioEnA_r, gpioEnA_nxt;
   logic [LINES_B-1:0] gpioEnB_r, gpioEnB_nxt;
   logic [FUNC_W-1:0] funcRc_r, funcRc_nxt;
   logic keep_r, keep_nxt;
   logic [DATA_W-1:0] regRdData_r, regRdData_nxt;
   // jtag sampling
   logic [SYNC_STAGES-1:0] tckSync_r;
   logic [1:0] settle_r, settle_nxt;
   logic captured_r, captured_nxt;
   logic jtagEn_r, jtagEn_nxt;
   // line outputs
   logic [LINES_A-1:0] pullUpA_r, pullUpA_nxt;
   logic [LINES_B-1:0] pullUpB_r, pullUpB_nxt;
   logic [LINES_A-1:0] gpioOwnA_r, gpioOwnA_nxt;
   logic [LINES_B-1:0] gpioOwnB_r, gpioOwnB_nxt;
   logic jtagOwn_r, jtagOwn_nxt;
   // rc clock path, kept in the power-up domain
   logic [SYNC_STAGES-1:0] rcSync_r;
   logic rcAlive_r, rcAlive_nxt;
   logic rcClkOut_r, rcClkOut_nxt;
   logic rcKill;

   function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
      hit = (a == ofs);
   endfunction

   // register file
   always_comb begin
      pullA_nxt = pullA_r;
      pullB_nxt = pullB_r;
      gpioEnA_nxt = gpioEnA_r;
      gpioEnB_nxt = gpioEnB_r;
      funcRc_nxt = funcRc_r;
      keep_nxt = keep_r;
      if (regWrite) begin
         if (hit(regAddr, OFS_PULL_A)) begin
            pullA_nxt = regWrData[LINES_A-1:0];
         end
         if (hit(regAddr, OFS_PULL_B)) begin
            pullB_nxt = regWrData[LINES_B-1:0];
         end
         if (hit(regAddr, OFS_GPIO_A)) begin
            gpioEnA_nxt = regWrData[LINES_A-1:0];
         end
         if (hit(regAddr, OFS_GPIO_B)) begin
            gpioEnB_nxt = regWrData[LINES_B-1:0];
         end
         if (hit(regAddr, OFS_FUNC_RC)) begin
            funcRc_nxt = regWrData[FUNC_W-1:0];
         end
         if (hit(regAddr, OFS_PWR_CTRL)) begin
            keep_nxt = regWrData[KEEP_BIT];
         end
      end
      regRdData_nxt = '0;
      if (regRead) begin
         if (hit(regAddr, OFS_PULL_A)) begin
            regRdData_nxt[LINES_A-1:0] = pullA_r;
         end
         if (hit(regAddr, OFS_PULL_B)) begin
            regRdData_nxt[LINES_B-1:0] = pullB_r;
         end
         if (hit(regAddr, OFS_GPIO_A)) begin
            regRdData_nxt[LINES_A-1:0] = gpioEnA_r;
         end
         if (hit(regAddr, OFS_GPIO_B)) begin
            regRdData_nxt[LINES_B-1:0] = gpioEnB_r;
         end
         if (hit(regAddr, OFS_FUNC_RC)) begin
            regRdData_nxt[FUNC_W-1:0] = funcRc_r;
         end
         if (hit(regAddr, OFS_PWR_CTRL)) begin
            regRdData_nxt[KEEP_BIT] = keep_r;
         end
         if (hit(regAddr, OFS_STATUS)) begin
            regRdData_nxt[STAT_JTAG] = jtagEn_r;
            regRdData_nxt[STAT_RC] = rcAlive_r;
         end
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         pullA_r <= PULL_A_RST[LINES_A-1:0];
         pullB_r <= PULL_B_RST[LINES_B-1:0];
         gpioEnA_r <= GPIO_A_RST[LINES_A-1:0];
         gpioEnB_r <= GPIO_B_RST[LINES_B-1:0];
         funcRc_r <= FUNC_F;
         keep_r <= 1'b1;
         regRdData_r <= '0;
      end else begin
         pullA_r <= pullA_nxt;
         pullB_r <= pullB_nxt;
         gpioEnA_r <= gpioEnA_nxt;
         gpioEnB_r <= gpioEnB_nxt;
         funcRc_r <= funcRc_nxt;
         keep_r <= keep_nxt;
         regRdData_r <= regRdData_nxt;
      end
   end

   // jtag decision: the pin is synchronised, so the capture waits until the
   // chain holds a sample taken after release rather than its reset value
   always_comb begin
      settle_nxt = settle_r;
      captured_nxt = captured_r;
      jtagEn_nxt = jtagEn_r;
      if (!captured_r) begin
         if (settle_r == 2'(SYNC_STAGES)) begin
            captured_nxt = 1'b1;
            jtagEn_nxt = ~tckSync_r[SYNC_STAGES-1];
         end else begin
            settle_nxt = settle_r + 2'h1;
         end
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         tckSync_r <= '1;
         settle_r <= 2'h0;
         captured_r <= 1'b0;
         jtagEn_r <= 1'b0;
      end else begin
         tckSync_r <= {tckSync_r[SYNC_STAGES-2:0], tckPin};
         settle_r <= settle_nxt;
         captured_r <= captured_nxt;
         jtagEn_r <= jtagEn_nxt;
      end
   end

   // line outputs
   always_comb begin
      pullUpA_nxt = pullA_r;
      gpioOwnA_nxt = gpioEnA_r;
      if (!captured_r) begin
         pullUpA_nxt = pullA_r | TCK_MASK[LINES_A-1:0];
      end
      if (jtagEn_r) begin
         pullUpA_nxt = (pullA_r | JTAG_PULL_MASK[LINES_A-1:0]) & ~TDO_MASK[LINES_A-1:0];
         gpioOwnA_nxt = gpioEnA_r & ~JTAG_MASK[LINES_A-1:0];
      end
      pullUpB_nxt = pullB_r;
      gpioOwnB_nxt = gpioEnB_r;
      jtagOwn_nxt = jtagEn_r;
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         pullUpA_r <= PULL_A_RST[LINES_A-1:0];
         pullUpB_r <= PULL_B_RST[LINES_B-1:0];
         gpioOwnA_r <= GPIO_A_RST[LINES_A-1:0];
         gpioOwnB_r <= GPIO_B_RST[LINES_B-1:0];
         jtagOwn_r <= 1'b0;
      end else begin
         pullUpA_r <= pullUpA_nxt;
         pullUpB_r <= pullUpB_nxt;
         gpioOwnA_r <= gpioOwnA_nxt;
         gpioOwnB_r <= gpioOwnB_nxt;
         jtagOwn_r <= jtagOwn_nxt;
      end
   end

   // rc clock: only a power cycle resets this group, so system reset never
   // interrupts the clock nor revives a stopped one
   always_comb begin
      rcKill = gpioEnA_r[RC_LINE] | (funcRc_r != FUNC_F) | ~keep_r;
      rcAlive_nxt = rcAlive_r & ~rcKill;
      rcClkOut_nxt = rcAlive_nxt & rcSync_r[SYNC_STAGES-1];
   end

   always_ff @(posedge core_clk or negedge powerUp_n) begin
      if (!powerUp_n) begin
         rcSync_r <= '0;
         rcAlive_r <= 1'b1;
         rcClkOut_r <= 1'b0;
      end else begin
         rcSync_r <= {rcSync_r[SYNC_STAGES-2:0], rcOscClk};
         rcAlive_r <= rcAlive_nxt;
         rcClkOut_r <= rcClkOut_nxt;
      end
   end

   assign regRdData = regRdData_r;
   assign pullUpA = pullUpA_r;
   assign pullUpB = pullUpB_r;
   assign gpioOwnA = gpioOwnA_r;
   assign gpioOwnB = gpioOwnB_r;
   assign rcLineFunc = funcRc_r;
   assign jtagOwn = jtagOwn_r;
   assign tdoOutEnable = jtagOwn_r;
   assign rcClkOut = rcClkOut_r;
   assign rcClkOutEnable = rcAlive_r;

   // checks
   sequence pullWriteA;
      regWrite && hit(regAddr, OFS_PULL_A) && captured_r && !jtagEn_r;
   endsequence
   sequence quietA;
      !(regWrite && hit(regAddr, OFS_PULL_A));
   endsequence

   chk_jtag_decision: assert property (@(posedge core_clk) disable iff (!reset_n)
      $rose(captured_r) |-> jtagEn_r == !$past(tckSync_r[SYNC_STAGES-1]))
      else $error("jtag decision does not match sampled test clock");
   chk_jtag_pullups: assert property (@(posedge core_clk) disable iff (!reset_n)
      jtagEn_r |=> pullUpA[TCK_LINE] && pullUpA[TMS_LINE] && pullUpA[TDI_LINE]
         && !pullUpA[TDO_LINE] && tdoOutEnable)
      else $error("jtag pull-ups or tdo drive wrong");
   chk_tck_pull_reset: assert property (@(posedge core_clk) disable iff (!reset_n)
      !captured_r |-> pullUpA[TCK_LINE])
      else $error("test clock pull-up lost before decision");
   chk_jtag_release: assert property (@(posedge core_clk) disable iff (!reset_n)
      captured_r && !jtagEn_r |=> !jtagOwn && gpioOwnA == $past(gpioEnA_r))
      else $error("jtag lines not released to gpio");
   chk_twi_default: assert property (@(posedge core_clk) disable iff (!reset_n)
      $rose(reset_n) |-> (gpioOwnA & TWI_A_MASK[LINES_A-1:0]) == '0
         && (gpioOwnB & TWI_B_MASK[LINES_B-1:0]) == '0)
      else $error("two-wire pins not on two-wire function after reset");
   chk_pull_program: assert property (@(posedge core_clk) disable iff (!reset_n)
      pullWriteA ##1 quietA |=> pullUpA == $past(regWrData[LINES_A-1:0], 2))
      else $error("written pull-up value not applied");
   chk_reset_defaults: assert property (@(posedge core_clk) disable iff (!reset_n)
      $rose(reset_n) |-> pullUpA == PULL_A_RST[LINES_A-1:0] && pullUpB == '0)
      else $error("pull-up reset defaults wrong");
   chk_rc_default: assert property (@(posedge core_clk) disable iff (!reset_n)
      $rose(reset_n) |-> rcLineFunc == FUNC_F && !gpioOwnA[RC_LINE])
      else $error("line twenty not on function F after reset");
   chk_rc_running: assert property (@(posedge core_clk) disable iff (!powerUp_n)
      rcAlive_r && !rcKill |=> rcClkOut == $past(rcSync_r[SYNC_STAGES-1]) && rcClkOutEnable)
      else $error("rc clock not forwarded");
   chk_rc_func_stop: assert property (@(posedge core_clk) disable iff (!powerUp_n)
      (gpioEnA_r[RC_LINE] || funcRc_r != FUNC_F) |=> !rcClkOutEnable && !rcClkOut)
      else $error("rc clock not stopped on function change");
   chk_rc_keep_stop: assert property (@(posedge core_clk) disable iff (!powerUp_n)
      regWrite && reset_n && hit(regAddr, OFS_PWR_CTRL) && !regWrData[KEEP_BIT]
         |-> ##2 !rcClkOutEnable)
      else $error("rc clock not stopped by keep bit");
   chk_rc_sticky: assert property (@(posedge core_clk) disable iff (!powerUp_n)
      !rcClkOutEnable |=> !rcClkOutEnable && !rcClkOut)
      else $error("rc clock came back");
   chk_jtag_hold: assert property (@(posedge core_clk) disable iff (!reset_n)
      captured_r |=> captured_r && $stable(jtagEn_r) && jtagOwn == $past(jtagEn_r))
      else $error("jtag decision changed outside reset");
endmodule
`default_nettype wire

//--- tb/rc_osc_probe_model.sv
`timescale 1ns/100ps
`default_nettype none
module rc_osc_probe_model #(
   parameter int HALF_NS = 200
) (
   // probe control from the bench
   input wire logic tckLevel,
   // pins seen by the device
   output logic tckPin,
   output var logic rcOscClk
);
   // much faster than the real 32 kHz source to keep the run short;
   // the device resamples it, so only the presence of edges matters
   initial begin
      rcOscClk = 1'b0;
   end
   always #(HALF_NS) rcOscClk = ~rcOscClk;

   // the probe holds the test clock steady and never touches the reset pin
   assign tckPin = tckLevel;
endmodule
`default_nettype wire

//--- tb/tb_io_pin_reset_defaults.sv
`timescale 1ns/100ps
`default_nettype none
module tb_io_pin_reset_defaults;
   import io_pin_reset_pkg::*;
   localparam logic [DATA_W-1:0] MASK_A = (ONE << NUM_A) - ONE;
   localparam logic [ADDR_W-1:0] KILL_ADDR [3] = '{OFS_PWR_CTRL, OFS_FUNC_RC, OFS_GPIO_A};
   // line twenty goes to gpio only as an output; nothing outside drives it then
   localparam logic [DATA_W-1:0] KILL_DATA [3] = '{32'h0000_0000, 32'h0000_0002,
      GPIO_A_RST | RC_MASK};
   localparam logic [DATA_W-1:0] BACK_DATA [3] = '{ONE, 32'h0000_0005, GPIO_A_RST};

   logic core_clk = 1'b0;
   logic reset_n = 1'b0;
   logic powerUp_n = 1'b0;
   logic [ADDR_W-1:0] regAddr = 5'h00;
   logic [DATA_W-1:0] regWrData = 32'h0000_0000;
   logic regWrite = 1'b0;
   logic regRead = 1'b0;
   logic [DATA_W-1:0] regRdData;
   logic tckLevel = 1'b0;
   logic tckPin;
   logic rcOscClk;
   logic [NUM_A-1:0] pullUpA;
   logic [NUM_B-1:0] pullUpB;
   logic [NUM_A-1:0] gpioOwnA;
   logic [NUM_B-1:0] gpioOwnB;
   logic [FUNC_W-1:0] rcLineFunc;
   logic jtagOwn;
   logic tdoOutEnable;
   logic rcClkOut;
   logic rcClkOutEnable;
   int mismatches = 0;
   int check_count = 0;

   always #10 core_clk = ~core_clk;

   rc_osc_probe_model i_partner (
      .tckLevel(tckLevel),
      .tckPin(tckPin),
      .rcOscClk(rcOscClk)
   );

   io_pin_reset_defaults i_dut (
      .core_clk(core_clk),
      .reset_n(reset_n),
      .powerUp_n(powerUp_n),
      .regAddr(regAddr),
      .regWrData(regWrData),
      .regWrite(regWrite),
      .regRead(regRead),
      .regRdData(regRdData),
      .tckPin(tckPin),
      .rcOscClk(rcOscClk),
      .pullUpA(pullUpA),
      .pullUpB(pullUpB),
      .gpioOwnA(gpioOwnA),
      .gpioOwnB(gpioOwnB),
      .rcLineFunc(rcLineFunc),
      .jtagOwn(jtagOwn),
      .tdoOutEnable(tdoOutEnable),
      .rcClkOut(rcClkOut),
      .rcClkOutEnable(rcClkOutEnable)
   );

   task automatic chk(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
      check_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask

   task automatic complete_run;
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   task automatic cycles(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask

   task automatic regWr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge core_clk);
      regWrite <= 1'b1;
      regAddr <= a;
      regWrData <= d;
      @(posedge core_clk);
      regWrite <= 1'b0;
   endtask

   // read data stand only in the cycle after the strobe
   task automatic regRd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
      @(posedge core_clk);
      regRead <= 1'b1;
      regAddr <= a;
      @(posedge core_clk);
      regRead <= 1'b0;
      #1;
      d = regRdData;
   endtask

   task automatic doReset(input int hold, input logic tck, input logic power);
      @(posedge core_clk);
      reset_n <= 1'b0;
      tckLevel <= tck;
      if (power) begin
         powerUp_n <= 1'b0;
      end
      repeat (2) @(posedge core_clk);
      powerUp_n <= 1'b1;
      repeat (hold - 2) @(posedge core_clk);
      reset_n <= 1'b1;
   endtask

   task automatic countToggles(input int n, output int k);
      logic prev;
      k = 0;
      prev = rcClkOut;
      repeat (n) begin
         @(posedge core_clk);
         #1;
         if (rcClkOut !== prev) begin
            k++;
         end
         prev = rcClkOut;
      end
   endtask

   initial begin
      #(20 * 8000);
      mismatches++;
      complete_run();
   end

   initial begin
      logic [DATA_W-1:0] rd;
      int k;
      repeat (2) @(posedge core_clk);
      powerUp_n <= 1'b1;
      cycles(2);
      chk(32'(pullUpA), PULL_A_RST);
      chk(32'(pullUpB), PULL_B_RST);
      chk(32'(gpioOwnA), GPIO_A_RST & MASK_A);
      chk(32'(gpioOwnB), GPIO_B_RST & ((ONE << NUM_B) - ONE));
      chk(32'(rcLineFunc), 32'(FUNC_F));
      chk(32'(jtagOwn), 32'h0000_0000);
      repeat (2) @(posedge core_clk);
      reset_n <= 1'b1;
      cycles(8);
      chk(32'(jtagOwn), ONE);
      chk(32'(tdoOutEnable), ONE);
      chk(32'(pullUpA) & JTAG_MASK, JTAG_PULL_MASK);
      chk(32'(gpioOwnA) & JTAG_MASK, 32'h0000_0000);
      @(posedge core_clk);
      tckLevel <= 1'b1;
      cycles(10);
      chk(32'(jtagOwn), ONE);
      regRd(OFS_STATUS, rd);
      chk(rd, 32'h0000_0003);
      // rc clock keeps running while reset_n holds the rest of the device
      fork
         doReset(40, 1'b1, 1'b0);
         begin
            cycles(5);
            chk(32'(pullUpA), PULL_A_RST);
            countToggles(30, k);
            chk(32'(k != 0), ONE);
            chk(32'(rcClkOutEnable), ONE);
         end
      join
      cycles(8);
      chk(32'(jtagOwn), 32'h0000_0000);
      chk(32'(tdoOutEnable), 32'h0000_0000);
      chk(32'(gpioOwnA), GPIO_A_RST & MASK_A);
      chk(32'(pullUpA), PULL_A_RST);
      regWr(OFS_PULL_A, MASK_A);
      cycles(2);
      chk(32'(pullUpA), MASK_A);
      regWr(OFS_PULL_B, 32'h0000_0A5A);
      regRd(OFS_PULL_B, rd);
      chk(rd, 32'h0000_0A5A);
      chk(32'(pullUpB), 32'h0000_0A5A);
      regRd(5'h1C, rd);
      chk(rd, 32'h0000_0000);
      regRd(OFS_PWR_CTRL, rd);
      chk(rd, ONE);
      regRd(OFS_GPIO_A, rd);
      chk(rd, GPIO_A_RST & MASK_A);
      regWr(OFS_GPIO_B, 32'h0000_0030);
      regRd(OFS_GPIO_B, rd);
      chk(rd, 32'h0000_0030);
      chk(32'(gpioOwnB), 32'h0000_0030);
      // keep bit cleared, function moved off F, line handed to the GPIO controller
      for (int i = 0; i < 3; i++) begin
         doReset(6, 1'b1, 1'b1);
         cycles(6);
         chk(32'(rcClkOutEnable), ONE);
         regWr(KILL_ADDR[i], KILL_DATA[i]);
         cycles(3);
         chk(32'(rcClkOutEnable), 32'h0000_0000);
         regWr(KILL_ADDR[i], BACK_DATA[i]);
         doReset(6, 1'b1, 1'b0);
         cycles(6);
         countToggles(40, k);
         chk(32'(k), 32'h0000_0000);
         chk(32'(rcClkOut), 32'h0000_0000);
         chk(32'(rcClkOutEnable), 32'h0000_0000);
         regRd(OFS_STATUS, rd);
         chk(rd, 32'h0000_0000);
      end
      complete_run();
   end
endmodule
`default_nettype wire
